// [rtl/bspl_boot_loader.v]
// Boot, security and PLL setup block with APB register access
`timescale 1ns/1ps
`include "bspl_defs.vh"
module bspl_boot_loader
(
  // Clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // Strap pins
  input  wire [1:0]  modePins,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // OTP read port, one cycle latency
  output reg  [10:0] otpAddr,
  output reg         otpRd,
  input  wire [31:0] otpData,
  // Flash byte stream
  input  wire        flashValid,
  input  wire [7:0]  flashByte,
  output reg         flashReady,
  // SRAM write port
  output reg         ramWe,
  output reg  [15:0] ramAddr,
  output reg  [31:0] ramWdata,
  // Core start and PLL settings
  output reg         coreRun,
  output reg  [15:0] coreEntry,
  output reg  [2:0]  pllOutputDivider,
  output reg  [11:0] pllFeedback,
  output reg  [5:0]  pllRefDivider,
  output reg  [7:0]  pllRatio,
  // Security enforcement
  output reg         gpioPullDown,
  output reg         jtagBlock,
  output reg         linkBlock,
  output reg         jtagOtpBlock,
  output reg         debugPinDisable,
  output reg         otpProgGrant
);
  // States
  localparam [3:0] ST_RESET = 4'h0;
  localparam [3:0] ST_SECRD = 4'h1;
  localparam [3:0] ST_SECWT = 4'h2;
  localparam [3:0] ST_SELECT= 4'h3;
  localparam [3:0] ST_OTPRD = 4'h4;
  localparam [3:0] ST_OTPWT = 4'h5;
  localparam [3:0] ST_COUNT = 4'h6;
  localparam [3:0] ST_PROG  = 4'h7;
  localparam [3:0] ST_CHECK = 4'h8;
  localparam [3:0] ST_RUN   = 4'h9;
  localparam [3:0] ST_ERROR = 4'ha;

  localparam integer RST_CYC = `BSPL_RST_US * `BSPL_CLK_MHZ;

  // CRC of one byte, reflected
  function [31:0] crcByte;
    input [31:0] c;
    input [7:0]  b;
    integer      i;
    reg   [31:0] t;
    begin
      t = c ^ {24'h000000, b};
      for (i = 0; i < 8; i = i + 1)
      begin
        t = t[0] ? ((t >> 1) ^ `BSPL_CRC_POLY) : (t >> 1);
      end
      crcByte = t;
    end
  endfunction

  // Strap sync and capture
  reg  [1:0]  modeS1_ff;
  reg  [1:0]  modeS2_ff;
  reg  [1:0]  mode_ff;
  reg  [3:0]  state_ff;
  reg  [11:0] dly_ff;
  reg  [31:0] sec_ff;
  reg         secValid_ff;
  reg  [31:0] crc_ff;
  reg  [31:0] word_ff;
  reg  [31:0] count_ff;
  reg  [1:0]  bcnt_ff;
  reg  [15:0] ptr_ff;
  reg         bootErr_ff;
  reg         progReq_ff;
  reg  [10:0] progAddr_ff;
  reg         progReject_ff;
  reg         strapDone_ff;

  wire        apbWr = psel & penable & pwrite & pready;
  wire        apbRd = psel & ~pwrite & ~penable;
  wire        flashTake = flashValid & flashReady;
  wire [31:0] wordNext = {flashByte, word_ff[31:8]};
  wire        progSect = sec_ff[`BSPL_SEC_LOCK0 + progAddr_ff[`BSPL_OTP_AW-1:`BSPL_OTP_SECT_LSB]];

  always @(posedge mclk)
  begin
    modeS1_ff <= modePins;
    modeS2_ff <= modeS1_ff;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_ff        <= ST_RESET;
      dly_ff          <= 12'h000;
      sec_ff          <= 32'h00000000;
      secValid_ff     <= 1'b0;
      crc_ff          <= `BSPL_CRC_INIT;
      word_ff         <= 32'h00000000;
      count_ff        <= 32'h00000000;
      bcnt_ff         <= 2'h0;
      ptr_ff          <= 16'h0000;
      bootErr_ff      <= 1'b0;
      progReq_ff      <= 1'b0;
      progAddr_ff     <= 11'h000;
      progReject_ff   <= 1'b0;
      strapDone_ff    <= 1'b0;
      mode_ff         <= 2'h0;
      otpAddr         <= 11'h000;
      otpRd           <= 1'b0;
      flashReady      <= 1'b0;
      ramWe           <= 1'b0;
      ramAddr         <= 16'h0000;
      ramWdata        <= 32'h00000000;
      coreRun         <= 1'b0;
      coreEntry       <= 16'h0000;
      pllOutputDivider<= `BSPL_OD_RESET;
      pllFeedback     <= `BSPL_FB_MODE00;
      pllRefDivider   <= `BSPL_R_RESET;
      pllRatio        <= `BSPL_RATIO_MODE00;
      gpioPullDown    <= 1'b1;
      jtagBlock       <= 1'b1;
      linkBlock       <= 1'b1;
      jtagOtpBlock    <= 1'b1;
      debugPinDisable <= 1'b1;
      otpProgGrant    <= 1'b0;
      prdata          <= 32'h00000000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end
    else
    begin
      ramWe <= 1'b0;
      otpRd <= 1'b0;
      otpProgGrant <= 1'b0;
      // Strap latched once after release
      if (!strapDone_ff)
      begin
        strapDone_ff <= 1'b1;
        mode_ff      <= modeS2_ff;
        case (modeS2_ff)
          2'b00:
          begin
            pllFeedback <= `BSPL_FB_MODE00;
            pllRatio    <= `BSPL_RATIO_MODE00;
          end
          2'b11:
          begin
            pllFeedback <= `BSPL_FB_MODE11;
            pllRatio    <= `BSPL_RATIO_MODE11;
          end
          2'b10:
          begin
            pllFeedback <= `BSPL_FB_MODE10;
            pllRatio    <= `BSPL_RATIO_MODE10;
          end
          default:
          begin
            pllFeedback <= `BSPL_FB_MODE01;
            pllRatio    <= `BSPL_RATIO_MODE01;
          end
        endcase
        pllOutputDivider <= `BSPL_OD_RESET;
        pllRefDivider    <= `BSPL_R_RESET;
      end
      // JTAG, link and debug outputs follow the loaded word only
      if (secValid_ff)
      begin
        jtagBlock       <= sec_ff[`BSPL_SEC_NOJTAG];
        linkBlock       <= sec_ff[`BSPL_SEC_NOLINK];
        jtagOtpBlock    <= sec_ff[`BSPL_SEC_NOJTAGOTP];
        debugPinDisable <= sec_ff[`BSPL_SEC_NODEBUG];
      end
      gpioPullDown <= 1'b0;
      // OTP programming gate
      if (progReq_ff)
      begin
        progReq_ff <= 1'b0;
        if (!secValid_ff || sec_ff[`BSPL_SEC_MASTER] || progSect)
          progReject_ff <= 1'b1;
        else
          otpProgGrant <= 1'b1;
      end

      case (state_ff)
        ST_RESET:
        begin
          if (dly_ff == RST_CYC[11:0] - 12'h001)
            state_ff <= ST_SECRD;
          else
            dly_ff <= dly_ff + 12'h001;
        end
        ST_SECRD:
        begin
          otpAddr  <= 11'h000;
          otpRd    <= 1'b1;
          state_ff <= ST_SECWT;
        end
        ST_SECWT:
        begin
          if (!otpRd)
          begin
            sec_ff      <= otpData;
            secValid_ff <= 1'b1;
            state_ff    <= ST_SELECT;
          end
        end
        ST_SELECT:
        begin
          crc_ff  <= `BSPL_CRC_INIT;
          bcnt_ff <= 2'h0;
          ptr_ff  <= 16'h0000;
          if (sec_ff[`BSPL_SEC_OTPBOOT])
          begin
            otpAddr  <= 11'h000;
            state_ff <= ST_OTPRD;
          end
          else
          begin
            flashReady <= 1'b1;
            state_ff   <= ST_COUNT;
          end
        end
        ST_OTPRD:
        begin
          otpRd    <= 1'b1;
          state_ff <= ST_OTPWT;
        end
        ST_OTPWT:
        begin
          if (!otpRd)
          begin
            ramWe    <= 1'b1;
            ramAddr  <= ptr_ff;
            ramWdata <= otpData;
            ptr_ff   <= ptr_ff + 16'h0001;
            if (otpAddr == {`BSPL_OTP_AW{1'b1}})
            begin
              coreEntry <= 16'h0000;
              state_ff  <= ST_RUN;
            end
            else
            begin
              otpAddr  <= otpAddr + 11'h001;
              state_ff <= ST_OTPRD;
            end
          end
        end
        ST_COUNT:
        begin
          if (flashTake)
          begin
            word_ff <= wordNext;
            crc_ff  <= crcByte(crc_ff, flashByte);
            bcnt_ff <= bcnt_ff + 2'h1;
            if (bcnt_ff == 2'h3)
            begin
              count_ff <= wordNext;
              state_ff <= (wordNext == 32'h00000000) ? ST_CHECK : ST_PROG;
            end
          end
        end
        ST_PROG:
        begin
          if (flashTake)
          begin
            word_ff <= wordNext;
            crc_ff  <= crcByte(crc_ff, flashByte);
            bcnt_ff <= bcnt_ff + 2'h1;
            if (bcnt_ff == 2'h3)
            begin
              ramWe    <= 1'b1;
              ramAddr  <= ptr_ff;
              ramWdata <= wordNext;
              ptr_ff   <= ptr_ff + 16'h0001;
              count_ff <= count_ff - 32'h00000001;
              if (count_ff == 32'h00000001)
                state_ff <= ST_CHECK;
            end
          end
        end
        ST_CHECK:
        begin
          if (flashTake)
          begin
            word_ff <= wordNext;
            bcnt_ff <= bcnt_ff + 2'h1;
            if (bcnt_ff == 2'h3)
            begin
              flashReady <= 1'b0;
              if (wordNext == `BSPL_SKIP_CRC || wordNext == ~crc_ff)
              begin
                coreEntry <= 16'h0000;
                state_ff  <= ST_RUN;
              end
              else
              begin
                bootErr_ff <= 1'b1;
                state_ff   <= ST_ERROR;
              end
            end
          end
        end
        ST_RUN:
        begin
          coreRun <= 1'b1;
        end
        ST_ERROR:
        begin
          coreRun <= 1'b0;
        end
        default:
        begin
          state_ff <= ST_RESET;
        end
      endcase

      // APB slave: no wait states, pready high in the first access cycle
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable)
      begin
        pslverr <= ~(paddr == `BSPL_ADDR_PLL || paddr == `BSPL_ADDR_SECURE ||
                     paddr == `BSPL_ADDR_STATUS || paddr == `BSPL_ADDR_CTRL ||
                     paddr == `BSPL_ADDR_OTPPROG || paddr == `BSPL_ADDR_ENTRY);
      end
      if (apbRd)
      begin
        case (paddr)
          `BSPL_ADDR_PLL:
            prdata <= {11'h000, pllOutputDivider, pllFeedback, pllRefDivider};
          `BSPL_ADDR_SECURE:
            prdata <= sec_ff;
          `BSPL_ADDR_STATUS:
            prdata <= {20'h00000, progReject_ff, bootErr_ff, coreRun, secValid_ff, state_ff, mode_ff, 2'h0};
          `BSPL_ADDR_ENTRY:
            prdata <= {16'h0000, coreEntry};
          default:
            prdata <= 32'h00000000;
        endcase
      end
      if (apbWr && !pslverr)
      begin
        if (paddr == `BSPL_ADDR_PLL)
        begin
          pllRefDivider    <= pwdata[`BSPL_PLL_R_MSB:`BSPL_PLL_R_LSB];
          pllFeedback      <= pwdata[`BSPL_PLL_F_MSB:`BSPL_PLL_F_LSB];
          pllOutputDivider <= pwdata[`BSPL_PLL_OD_MSB:`BSPL_PLL_OD_LSB];
        end
        if (paddr == `BSPL_ADDR_OTPPROG)
        begin
          progReq_ff  <= 1'b1;
          progAddr_ff <= pwdata[`BSPL_OTP_AW-1:0];
        end
        if (paddr == `BSPL_ADDR_CTRL && pwdata[`BSPL_CTRL_CLR] && !progReq_ff)
          progReject_ff <= 1'b0;
      end
    end
  end
endmodule // bspl_boot_loader

// [rtl/bspl_defs.vh]
// Constants for the boot, security and PLL setup block
`ifndef BSPL_DEFS_VH
`define BSPL_DEFS_VH
// APB register byte addresses
`define BSPL_ADDR_PLL      12'h000
`define BSPL_ADDR_SECURE   12'h004
`define BSPL_ADDR_STATUS   12'h008
`define BSPL_ADDR_CTRL     12'h00c
`define BSPL_ADDR_OTPPROG  12'h010
`define BSPL_ADDR_ENTRY    12'h014
// Control register: write one to clear the refused-programming flag
`define BSPL_CTRL_CLR      0
// PLL field layout: R [5:0], F [17:6], OD [20:18]
`define BSPL_PLL_R_LSB     0
`define BSPL_PLL_R_MSB     5
`define BSPL_PLL_F_LSB     6
`define BSPL_PLL_F_MSB     17
`define BSPL_PLL_OD_LSB    18
`define BSPL_PLL_OD_MSB    20
// Strap table
`define BSPL_FB_MODE00     12'h09f
`define BSPL_FB_MODE11     12'h03f
`define BSPL_FB_MODE10     12'h01f
`define BSPL_FB_MODE01     12'h00f
`define BSPL_RATIO_MODE00  8'h28
`define BSPL_RATIO_MODE11  8'h10
`define BSPL_RATIO_MODE10  8'h08
`define BSPL_RATIO_MODE01  8'h04
`define BSPL_OD_RESET      3'h1
`define BSPL_R_RESET       6'h00
// Security word bits
`define BSPL_SEC_NOJTAG    0
`define BSPL_SEC_NOLINK    1
`define BSPL_SEC_OTPBOOT   5
`define BSPL_SEC_LOCK0     8
`define BSPL_SEC_MASTER    12
`define BSPL_SEC_NOJTAGOTP 13
`define BSPL_SEC_NODEBUG   14
// OTP geometry: 4 sectors of 512 rows
`define BSPL_OTP_AW        11
`define BSPL_OTP_SECT_LSB  9
// Boot image
`define BSPL_SKIP_CRC      32'h0d15ab1e
`define BSPL_CRC_POLY      32'hedb88320
`define BSPL_CRC_INIT      32'hffffffff
// Internal reset delay: 15 us at 50 MHz
`define BSPL_CLK_MHZ       50
`define BSPL_RST_US        15
`endif

// [tb/bspl_boot_partner.sv]
// Flash byte source and OTP array facing the boot loader
`timescale 1ns/1ps
module bspl_boot_partner
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // OTP read port
  input  wire logic [10:0] otpAddr,
  input  wire logic        otpRd,
  output logic      [31:0] otpData,
  // Flash stream
  input  wire logic        flashReady,
  output logic             flashValid,
  output logic      [7:0]  flashByte
);
  logic [31:0] otp [0:2047];
  logic [7:0]  img [0:255];
  int          imgLen;
  int          ptr;
  logic        slow;

  initial
  begin
    otpData = 32'h0;
    flashValid = 1'b0;
    flashByte = 8'h00;
    imgLen = 0;
    slow = 1'b0;
  end
  // Data only good the cycle after a read
  always @(posedge mclk)
    otpData <= otpRd ? otp[otpAddr] : ~otpData;
  // Slow mode drops valid after every byte
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      ptr <= 0;
      flashValid <= 1'b0;
    end
    else if (flashValid && flashReady)
    begin
      ptr <= ptr + 1;
      flashValid <= !slow && ptr + 1 < imgLen;
      flashByte <= (!slow && ptr + 1 < imgLen) ? img[ptr + 1] : ~flashByte;
    end
    else if (!flashValid && ptr < imgLen)
    begin
      flashValid <= 1'b1;
      flashByte <= img[ptr];
    end
    else if (!flashValid)
      flashByte <= ~flashByte;
  end
endmodule // bspl_boot_partner

// [tb/bspl_boot_loader_assertions.sv]
// Port assertions for the boot loader
`timescale 1ns/1ps
`include "bspl_defs.vh"
module bspl_boot_checker
(
  input wire        mclk,
  input wire        rstn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // OTP, RAM and core
  input wire [10:0] otpAddr,
  input wire        otpRd,
  input wire [31:0] otpData,
  input wire        ramWe,
  input wire [15:0] ramAddr,
  input wire        coreRun,
  input wire [15:0] coreEntry,
  // PLL and security
  input wire [2:0]  pllOutputDivider,
  input wire [11:0] pllFeedback,
  input wire [5:0]  pllRefDivider,
  input wire [7:0]  pllRatio,
  input wire        gpioPullDown,
  input wire        jtagBlock,
  input wire        linkBlock,
  input wire        jtagOtpBlock,
  input wire        debugPinDisable,
  input wire        otpProgGrant
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [31:0] secW;
  logic [10:0] row;
  logic [15:0] expA;
  logic        rd0;
  logic        seen;
  int          cyc;

  always @(posedge mclk)
  begin
    rd0 <= otpRd && otpAddr == 11'h000;
    if (rd0)
      secW <= otpData;
    if (psel && penable && pready && pwrite && paddr == `BSPL_ADDR_OTPPROG)
      row <= pwdata[10:0];
    if (!rstn)
    begin
      expA <= 16'h0000;
      cyc <= 0;
      seen <= 1'b0;
    end
    else
    begin
      expA <= expA + {15'h0, ramWe};
      cyc <= (cyc < 8000) ? cyc + 1 : cyc;
      seen <= seen | otpRd;
    end
  end

  a_reset_pins:
    assert property (disable iff (1'b0) !rstn |=> gpioPullDown && jtagBlock && linkBlock && jtagOtpBlock)
      else $error("reset pins wrong");
  a_pll_reset:
    assert property (disable iff (1'b0) !rstn |=> pllFeedback == 12'h09f && pllOutputDivider == 3'h1
                     && pllRefDivider == 6'h00 && pllRatio == 8'h28)
      else $error("pll reset wrong");
  a_apb_answer:
    assert property (psel && !penable |=> pready)
      else $error("apb answer late");
  a_apb_refuse:
    assert property (pready |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'b00))
      else $error("apb error flag wrong");
  a_ram_order:
    assert property (ramWe |-> ramAddr == expA)
      else $error("ram address wrong");
  a_entry_zero:
    assert property (coreRun |-> coreEntry == 16'h0000)
      else $error("entry not zero");
  a_boot_delay:
    assert property (otpRd && !seen |-> cyc >= 749 && cyc <= 7500)
      else $error("boot delay wrong");
  a_sec_mirror:
    assert property ($changed({debugPinDisable, jtagOtpBlock, linkBlock, jtagBlock})
                     |-> {debugPinDisable, jtagOtpBlock, linkBlock, jtagBlock} == {secW[14], secW[13], secW[1:0]})
      else $error("security outputs wrong");
  a_grant_lock:
    assert property (otpProgGrant |-> !secW[12] && !secW[8 + row[10:9]])
      else $error("locked row granted");
  c_run: cover property ($rose(coreRun));
  c_grant: cover property (otpProgGrant);
  c_refuse: cover property (pready && pslverr);
endmodule // bspl_boot_checker

bind bspl_boot_loader bspl_boot_checker chk (.*);

// [tb/bspl_boot_loader_test.sv]
// Self-checking bench for the boot loader
`timescale 1ns/1ps
`include "bspl_defs.vh"
module bspl_boot_loader_test;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  modePins = 2'b00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata, otpData, ramWdata;
  wire         pready, pslverr, otpRd, flashValid, flashReady, ramWe, coreRun, otpProgGrant;
  wire         gpioPullDown, jtagBlock, linkBlock, jtagOtpBlock, debugPinDisable;
  wire  [10:0] otpAddr;
  wire  [7:0]  flashByte, pllRatio;
  wire  [15:0] ramAddr, coreEntry;
  wire  [2:0]  pllOutputDivider;
  wire  [11:0] pllFeedback;
  wire  [5:0]  pllRefDivider;
  int          bad_count = 0;
  int          total_checks = 0;
  int          grants = 0;
  logic [31:0] ram [0:2047];
  logic [31:0] crc, rd;
  logic        err;
  logic [11:0] fbTab [4] = '{12'h09f, 12'h00f, 12'h01f, 12'h03f};
  logic [7:0]  raTab [4] = '{8'h28, 8'h04, 8'h08, 8'h10};

  bspl_boot_loader dut (.*);
  bspl_boot_partner fm (.*);
  always #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (ramWe === 1'b1)
      ram[ramAddr[10:0]] <= ramWdata;
    if (otpProgGrant === 1'b1)
      grants <= grants + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Answer taken at the rising edge that samples pready high
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic doReset(input logic [1:0] m);
    @(posedge mclk);
    modePins <= m;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check({gpioPullDown, jtagBlock, linkBlock, jtagOtpBlock, debugPinDisable}, 5'h1f);
    foreach (ram[i]) ram[i] = 32'hx;
    @(posedge mclk);
    rstn <= 1'b1;
  endtask
  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int j = 0; j < 8; j++)
      c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    return c;
  endfunction
  task automatic putWord(input logic [31:0] w);
    for (int k = 0; k < 4; k++)
    begin
      fm.img[fm.imgLen] = w[8*k +: 8];
      fm.imgLen++;
      crc = crcByte(crc, w[8*k +: 8]);
    end
  endtask
  task automatic waitBoot();
    int t;
    t = 0;
    for (int i = 0; i < 9000 && coreRun !== 1'b1 && t < 40; i++)
    begin
      @(posedge mclk);
      if (fm.imgLen > 0 && fm.ptr == fm.imgLen)
        t++;
    end
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    int g;
    foreach (fm.otp[i]) fm.otp[i] = i;
    for (int m = 0; m < 4; m++)
    begin
      doReset(m[1:0]);
      repeat (4) @(posedge mclk);
      #1;
      check({pllOutputDivider, pllRefDivider, pllRatio, pllFeedback}, {3'h1, 6'h00, raTab[m], fbTab[m]});
    end
    $display("straps done");
    apb(1'b1, `BSPL_ADDR_PLL, {11'h0, 3'h3, 12'h123, 6'h05});
    #1;
    check({pllOutputDivider, pllFeedback, pllRefDivider}, {3'h3, 12'h123, 6'h05});
    apb(1'b0, `BSPL_ADDR_PLL, 32'h0);
    check(rd, {11'h0, 3'h3, 12'h123, 6'h05});
    apb(1'b0, 12'h020, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    $display("registers done");
    fm.otp[0] = 32'h00000203;
    fm.imgLen = 0;
    putWord(32'h2);
    putWord(32'h1111aaaa);
    putWord(32'h2222bbbb);
    putWord(32'h0d15ab1e);
    doReset(2'b01);
    waitBoot();
    check(coreRun, 1'b1);
    check(ram[0], 32'h1111aaaa);
    check(ram[1], 32'h2222bbbb);
    check({gpioPullDown, jtagBlock, linkBlock, jtagOtpBlock, debugPinDisable}, 5'h0c);
    g = grants;
    apb(1'b1, `BSPL_ADDR_OTPPROG, 32'h005);
    apb(1'b1, `BSPL_ADDR_OTPPROG, 32'h205);
    apb(1'b0, `BSPL_ADDR_STATUS, 32'h0);
    check(rd[11:8], 4'hb);
    check(grants - g, 32'h1);
    apb(1'b1, `BSPL_ADDR_CTRL, 32'h1);
    apb(1'b0, `BSPL_ADDR_STATUS, 32'h0);
    check(rd[11], 1'b0);
    $display("flash boot done");
    for (int b = 0; b < 2; b++)
    begin
      fm.otp[0] = 32'h0;
      fm.imgLen = 0;
      fm.slow = 1'b1;
      crc = 32'hffffffff;
      putWord(32'h1);
      putWord(32'h3c3c0f0f);
      putWord(~crc ^ b);
      doReset(2'b01);
      waitBoot();
      apb(1'b0, `BSPL_ADDR_STATUS, 32'h0);
      check({coreRun, rd[10]}, {b == 0, b == 1});
      check(ram[0], 32'h3c3c0f0f);
    end
    $display("crc done");
    fm.otp[0] = 32'h00005020;
    fm.imgLen = 0;
    doReset(2'b01);
    waitBoot();
    check(coreRun, 1'b1);
    check(ram[0], 32'h00005020);
    check(ram[2047], 32'h7ff);
    check({jtagBlock, linkBlock, jtagOtpBlock, debugPinDisable}, 4'h1);
    g = grants;
    apb(1'b1, `BSPL_ADDR_OTPPROG, 32'h005);
    apb(1'b0, `BSPL_ADDR_STATUS, 32'h0);
    check(rd[11], 1'b1);
    check(grants - g, 32'h0);
    $display("otp boot done");
    results();
  end

  initial
  begin
    #(20 * 30000);
    bad_count++;
    results();
  end
endmodule // bspl_boot_loader_test
